// ### src/lcfs_pkg.sv
// Shared constants, types and timing figures of the LED channel fault supervisor
//
// Operation
// - Open-load monitoring only while diagnostics enabled.
// - Open fault after low headroom outlasts deglitch.
// - Headroom above falling threshold restarts open deglitch.
// - Open fault pulls fault bus low.
// - Open fault stops regulation, sources retry current.
// - Open condition gone restores regulation, releases bus.
// - Single short flagged after low output deglitch.
// - Output above rising threshold clears short deglitch.
// - Short fault: channel off, 300us burst every 10ms.
// - Burst seeing output recovered clears short fault.
// - Diagnostic enable gates open and short diagnosis.
// - Thermal protection ignores diagnostic enable.
// - Thermal shutdown: outputs off, bus low, hysteresis.
// - No fault weak pull-up; fault strong pull-down.
// - External low bus shuts regulated current of unshorted channels until high.
// - Low dim input disables regulated current and diagnostics.
package lcfs_pkg;

  // ----------------------------------------------------------------
  // Channel count and clock
  // ----------------------------------------------------------------
  localparam int LCFS_NUM_CH = 3;           // Channels per device
  localparam int LCFS_CLK_PERIOD_NS = 40;   // Core clock period, 25 MHz

  // ----------------------------------------------------------------
  // Timebase and timing figures
  // ----------------------------------------------------------------
  localparam int LCFS_TICK_NS = 1000;       // Timebase tick, one microsecond
  localparam int LCFS_TICK_CYCLES = LCFS_TICK_NS / LCFS_CLK_PERIOD_NS;
  localparam int LCFS_TICK_W = 5;           // Divider width, holds TICK_CYCLES
  localparam int LCFS_RETRY_PERIOD_US = 10000; // Short retry period, 10 ms
  localparam int LCFS_RETRY_BURST_US = 300; // Full-current retry burst
  localparam int LCFS_OPEN_DEG_US = 10;     // Open deglitch, plain default
  localparam int LCFS_SLS_DEG_US = 10;      // Single-short deglitch, plain default
  localparam int LCFS_CNT_W = 14;           // Timer width, holds 10000 ticks

  // ----------------------------------------------------------------
  // Synchroniser layout and reset values
  // ----------------------------------------------------------------
  localparam int LCFS_CMP_W = 4;            // Comparator bits per channel
  localparam int LCFS_SYNC_W = LCFS_NUM_CH * (LCFS_CMP_W + 1) + 4;
  localparam logic LCFS_BUS_LEVEL_LOW = 1'b0; // Level driven when pulling bus

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Comparator results of one channel, produced by the analog front end
  typedef struct packed {
    logic open_rise_below;  // Headroom below open rising threshold
    logic open_fall_above;  // Headroom above open falling threshold
    logic sls_below;        // Scaled output below single-short falling threshold
    logic sls_above;        // Scaled output above single-short rising threshold
  } lcfs_cmp_s;

  // Channel supervisor states
  typedef enum logic [1:0] {
    LCFS_ST_NORMAL = 2'b00,
    LCFS_ST_OPEN = 2'b01,
    LCFS_ST_SHORT_OFF = 2'b10,
    LCFS_ST_SHORT_BURST = 2'b11
  } lcfs_state_e;

endpackage

// ### src/lcfs_channel.sv
// Fault state machine and deglitch/retry timers of one LED channel
`timescale 1ns/1ps
module lcfs_channel import lcfs_pkg::*; #(
  parameter int CNT_W = LCFS_CNT_W,
  parameter int OPEN_DEG_TICKS = LCFS_OPEN_DEG_US,
  parameter int SLS_DEG_TICKS = LCFS_SLS_DEG_US,
  parameter int PERIOD_TICKS = LCFS_RETRY_PERIOD_US,
  parameter int BURST_TICKS = LCFS_RETRY_BURST_US
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,          // One-cycle timebase enable
  input wire logic diag_i,          // Filtered diagnostic enable
  input wire logic dim_i,           // Filtered dimming input
  input wire logic global_off_i,    // Thermal or bus shutdown
  input wire lcfs_cmp_s cmp_i,      // Filtered comparator results
  output logic open_flag_o,
  output logic short_flag_o,
  output logic burst_o,
  output logic regulate_o,
  output logic retry_cur_o
);

  // ----------------------------------------------------------------
  // Sized timing limits
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] OPEN_LIM = CNT_W'(OPEN_DEG_TICKS);
  localparam logic [CNT_W-1:0] SLS_LIM = CNT_W'(SLS_DEG_TICKS);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_TICKS - 1);
  localparam logic [CNT_W-1:0] BURST_LAST = CNT_W'(BURST_TICKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  lcfs_state_e state;              // Current channel state
  lcfs_state_e next_state;
  logic [CNT_W-1:0] open_cnt;      // Open deglitch timer
  logic [CNT_W-1:0] sls_cnt;       // Single-short deglitch timer
  logic [CNT_W-1:0] retry_cnt;     // Retry period timer
  logic [CNT_W-1:0] next_open_cnt;
  logic [CNT_W-1:0] next_sls_cnt;
  logic [CNT_W-1:0] next_retry_cnt;

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  wire diag_on = diag_i & dim_i & ~global_off_i;
  // Restart when diagnosis is off, condition absent or hysteresis crossed
  wire open_restart = ~diag_on | ~cmp_i.open_rise_below | cmp_i.open_fall_above;
  wire sls_restart = ~diag_on | ~cmp_i.sls_below | cmp_i.sls_above;
  wire open_trip = ~open_restart & (open_cnt >= OPEN_LIM);
  wire sls_trip = ~sls_restart & (sls_cnt >= SLS_LIM);
  wire period_end = tick_i & (retry_cnt == PERIOD_LAST);
  wire burst_end = tick_i & (retry_cnt == BURST_LAST);
  wire in_normal = (state == LCFS_ST_NORMAL);
  wire in_short = (state == LCFS_ST_SHORT_OFF) | (state == LCFS_ST_SHORT_BURST);

  // Deglitch timers advance one step per tick; saturation not needed
  // because the trip moves the state out of normal on the same count
  assign next_open_cnt = (open_restart | ~in_normal) ? CNT_ZERO :
                         (tick_i ? open_cnt + CNT_ONE : open_cnt);
  assign next_sls_cnt = (sls_restart | ~in_normal) ? CNT_ZERO :
                        (tick_i ? sls_cnt + CNT_ONE : sls_cnt);
  // Retry timer free-runs over the whole period while a short is held
  assign next_retry_cnt = ~in_short ? CNT_ZERO :
                          (period_end ? CNT_ZERO :
                          (tick_i ? retry_cnt + CNT_ONE : retry_cnt));

  // ----------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      LCFS_ST_NORMAL: begin
        // Open takes priority: a lifted load also fails the short test
        if (open_trip) begin
          next_state = LCFS_ST_OPEN;
        end else if (sls_trip) begin
          next_state = LCFS_ST_SHORT_OFF;
        end
      end
      LCFS_ST_OPEN: begin
        // Recovery once headroom is back or diagnosis is switched off
        if (cmp_i.open_fall_above | ~diag_i) begin
          next_state = LCFS_ST_NORMAL;
        end
      end
      LCFS_ST_SHORT_OFF: begin
        if (~diag_i) begin
          next_state = LCFS_ST_NORMAL;
        end else if (period_end & dim_i & ~global_off_i) begin
          next_state = LCFS_ST_SHORT_BURST;
        end
      end
      LCFS_ST_SHORT_BURST: begin
        if (~diag_i) begin
          next_state = LCFS_ST_NORMAL;
        end else if (cmp_i.sls_above) begin
          next_state = LCFS_ST_NORMAL;
        end else if (burst_end | ~dim_i | global_off_i) begin
          next_state = LCFS_ST_SHORT_OFF;
        end
      end
      default: begin
        next_state = LCFS_ST_NORMAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State and timer registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= LCFS_ST_NORMAL;
      open_cnt <= CNT_ZERO;
      sls_cnt <= CNT_ZERO;
      retry_cnt <= CNT_ZERO;
    end else begin
      state <= next_state;
      open_cnt <= next_open_cnt;
      sls_cnt <= next_sls_cnt;
      retry_cnt <= next_retry_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs decoded from state; retry current also needs diag_i
  // ----------------------------------------------------------------
  assign open_flag_o = (state == LCFS_ST_OPEN);
  assign short_flag_o = in_short;
  assign burst_o = (state == LCFS_ST_SHORT_BURST);
  assign regulate_o = in_normal | burst_o;
  assign retry_cur_o = open_flag_o & diag_i;

endmodule

// ### src/lcfs_supervisor.sv
// Top of the LED channel fault supervisor: input filters, timebase, fault bus
`timescale 1ns/1ps
module lcfs_supervisor import lcfs_pkg::*; #(
  parameter int NUM_CH = LCFS_NUM_CH,
  parameter int RETRY_PERIOD_US = LCFS_RETRY_PERIOD_US,
  parameter int RETRY_BURST_US = LCFS_RETRY_BURST_US,
  parameter int OPEN_DEG_US = LCFS_OPEN_DEG_US,
  parameter int SLS_DEG_US = LCFS_SLS_DEG_US
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic diag_enable_in_i,               // Diagnostic enable pin
  input wire logic [NUM_CH-1:0] channel_dim_in_i,  // Per-channel dimming pins
  input wire lcfs_cmp_s [NUM_CH-1:0] channel_cmp_i, // Analog comparator results
  input wire logic thermal_shutdown_i,             // Over-temperature, with hysteresis
  input wire logic fault_bus_below_low_i,          // Bus sensed below low threshold
  input wire logic fault_bus_above_high_i,         // Bus sensed above high threshold
  output logic [NUM_CH-1:0] channel_output_regulate_o, // Regulate full current
  output logic [NUM_CH-1:0] channel_output_retry_o,    // Small retry current
  output logic [NUM_CH-1:0] channel_open_fault_o,
  output logic [NUM_CH-1:0] channel_short_fault_o,
  output logic fault_bus_o,                        // Driven level, always low
  output logic fault_bus_oe_o,                     // Strong pull-down active
  output logic fault_bus_weak_pullup_o             // Weak pull-up active
);

  // ----------------------------------------------------------------
  // Local sizes and constants
  // ----------------------------------------------------------------
  localparam int SYNC_W = NUM_CH * (LCFS_CMP_W + 1) + 4;
  localparam logic [LCFS_TICK_W-1:0] TICK_LAST = LCFS_TICK_W'(LCFS_TICK_CYCLES - 1);
  localparam logic [LCFS_TICK_W-1:0] TICK_ZERO = '0;
  localparam logic [LCFS_TICK_W-1:0] TICK_ONE = LCFS_TICK_W'(1);
  localparam logic [SYNC_W-1:0] SYNC_RESET = '0;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every input comes from analog comparators or pins outside the clock
  // domain. Three flops; a new level is accepted only when the second and
  // third agree, which also rejects single-cycle comparator chatter.
  logic [SYNC_W-1:0] sync_raw;   // Raw asynchronous inputs
  logic [SYNC_W-1:0] sync_s1;    // First stage, read only by second stage
  logic [SYNC_W-1:0] sync_s2;
  logic [SYNC_W-1:0] sync_s3;
  logic [SYNC_W-1:0] sync_filt;  // Accepted levels
  logic [SYNC_W-1:0] next_filt;

  assign sync_raw = {channel_cmp_i, channel_dim_in_i, diag_enable_in_i,
                     thermal_shutdown_i, fault_bus_below_low_i, fault_bus_above_high_i};
  // Keep the old level while stages two and three disagree
  assign next_filt = (sync_s2 & sync_s3) | (sync_filt & (sync_s2 | sync_s3));

  // Synchroniser chain
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_s1 <= SYNC_RESET;
      sync_s2 <= SYNC_RESET;
      sync_s3 <= SYNC_RESET;
      sync_filt <= SYNC_RESET;
    end else begin
      sync_s1 <= sync_raw;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      sync_filt <= next_filt;
    end
  end

  // ----------------------------------------------------------------
  // Filtered field split
  // ----------------------------------------------------------------
  wire lcfs_cmp_s [NUM_CH-1:0] cmp_f;
  wire [NUM_CH-1:0] dim_f;
  wire diag_f;
  wire tsd_f;
  wire bus_low_f;
  wire bus_high_f;
  assign {cmp_f, dim_f, diag_f, tsd_f, bus_low_f, bus_high_f} = sync_filt;

  // ----------------------------------------------------------------
  // Internal timebase
  // ----------------------------------------------------------------
  // One-microsecond enable; all deglitch and retry timers count it, so
  // their figures stay exact for any package clock period that splits a microsecond into at most 32 whole cycles
  logic [LCFS_TICK_W-1:0] tick_div; // Divider count
  logic tick;                       // One-cycle pulse each microsecond
  wire tick_wrap = (tick_div == TICK_LAST);

  // Divider
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_div <= TICK_ZERO;
      tick <= 1'b0;
    end else begin
      tick_div <= tick_wrap ? TICK_ZERO : tick_div + TICK_ONE;
      tick <= tick_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Fault bus sense with hysteresis
  // ----------------------------------------------------------------
  // The hold is set below the low threshold and cleared only above the
  // high one, so a bus sitting between the two keeps its last meaning.
  // Our own pull-down also trips it: every channel but a shorted one stops regulating with ours.
  logic bus_hold; // Bus is held low by someone
  wire next_bus_hold = bus_low_f | (bus_hold & ~bus_high_f);

  // Bus hold register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_hold <= 1'b0;
    end else begin
      bus_hold <= next_bus_hold;
    end
  end


  // ----------------------------------------------------------------
  // Channel supervisors
  // ----------------------------------------------------------------
  wire [NUM_CH-1:0] ch_open;
  wire [NUM_CH-1:0] ch_short;
  wire [NUM_CH-1:0] ch_burst;
  wire [NUM_CH-1:0] ch_regulate;
  wire [NUM_CH-1:0] ch_retry;

  // ----------------------------------------------------------------
  // Shutdown masks
  // ----------------------------------------------------------------
  // Thermal off needs no enable: it stands apart from diagnostics.
  // Our own sink also sets the hold, so a shorted channel is exempt;
  // else its own fault would block every retry burst for good.
  // Limitation: it still bursts while a peer holds the bus low.
  wire [NUM_CH-1:0] tsd_all = {NUM_CH{tsd_f}}; // Thermal off, all channels
  wire [NUM_CH-1:0] hold_all = {NUM_CH{bus_hold}}; // Bus hold, all channels
  wire [NUM_CH-1:0] hold_mask = ~ch_short; // Channels the hold may stop
  wire [NUM_CH-1:0] ch_off = tsd_all | (hold_all & hold_mask);

  // One independent supervisor per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      lcfs_channel #(
        .CNT_W(LCFS_CNT_W),
        .OPEN_DEG_TICKS(OPEN_DEG_US),
        .SLS_DEG_TICKS(SLS_DEG_US),
        .PERIOD_TICKS(RETRY_PERIOD_US),
        .BURST_TICKS(RETRY_BURST_US)
      ) u_channel (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .tick_i(tick),
        .diag_i(diag_f),
        .dim_i(dim_f[gi]),
        .global_off_i(ch_off[gi]),
        .cmp_i(cmp_f[gi]),
        .open_flag_o(ch_open[gi]),
        .short_flag_o(ch_short[gi]),
        .burst_o(ch_burst[gi]),
        .regulate_o(ch_regulate[gi]),
        .retry_cur_o(ch_retry[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  // Regulated current flows only with dim high and no global shutdown
  wire [NUM_CH-1:0] next_regulate = ch_regulate & dim_f & ~ch_off;
  // Retry current ignores dimming but not thermal shutdown
  wire [NUM_CH-1:0] next_retry = ch_retry & {NUM_CH{~tsd_f}};
  wire fault_any = (|ch_open) | (|ch_short) | tsd_f;

  // Output registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      channel_output_regulate_o <= '0;
      channel_output_retry_o <= '0;
      channel_open_fault_o <= '0;
      channel_short_fault_o <= '0;
      fault_bus_o <= LCFS_BUS_LEVEL_LOW;
      fault_bus_oe_o <= 1'b0;
      fault_bus_weak_pullup_o <= 1'b1;
    end else begin
      channel_output_regulate_o <= next_regulate;
      channel_output_retry_o <= next_retry;
      channel_open_fault_o <= ch_open;
      channel_short_fault_o <= ch_short;
      fault_bus_o <= LCFS_BUS_LEVEL_LOW;
      fault_bus_oe_o <= fault_any;
      fault_bus_weak_pullup_o <= ~fault_any;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // A filtered input takes one edge to reach the state and one more
  // to reach the output registers, so most checks look one edge past
  // their cause.


  bus_pull_a: assert property (fault_any |=> fault_bus_oe_o && !fault_bus_weak_pullup_o)
    else $error("fault present but bus not pulled low");
  bus_release_a: assert property (!fault_any |=> !fault_bus_oe_o && fault_bus_weak_pullup_o)
    else $error("bus pulled low without a fault");
  thermal_off_a: assert property (tsd_f |=> channel_output_regulate_o == '0 && fault_bus_oe_o)
    else $error("outputs on or bus released during thermal shutdown");
  bus_hold_off_a: assert property (bus_low_f |=> ##1
    (channel_output_regulate_o & ~channel_short_fault_o) == '0)
    else $error("outputs on while fault bus held low");
  bus_hyst_a: assert property (bus_hold && !bus_high_f |=> bus_hold)
    else $error("bus hold released before high threshold");
  tick_gap_a: assert property (tick |=> !tick [*8])
    else $error("timebase ticks too close together");

  thermal_retry_a: assert property (tsd_f |=> channel_output_retry_o == '0)
    else $error("retry current on during thermal shutdown");

  hold_clear_a: assert property (bus_hold && bus_high_f && !bus_low_f |=> !bus_hold)
    else $error("bus hold kept after bus went high");

  // Per-channel checks

  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chk
      open_diag_gate_a: assert property ($rose(ch_open[gi]) |->
        $past(diag_f) && $past(dim_f[gi]) && $past(cmp_f[gi].open_rise_below))
        else $error("open fault raised without enabled diagnosis");
      short_diag_gate_a: assert property ($rose(ch_short[gi]) |->
        $past(diag_f) && $past(dim_f[gi]) && $past(cmp_f[gi].sls_below))
        else $error("short fault raised without enabled diagnosis");
      open_reg_off_a: assert property (ch_open[gi] |=> !channel_output_regulate_o[gi])
        else $error("open channel still regulating");
      open_retry_a: assert property (ch_open[gi] && diag_f && !tsd_f |=>
        channel_output_retry_o[gi])
        else $error("open channel lacks retry current");
      short_off_a: assert property (ch_short[gi] && !ch_burst[gi] |=>
        !channel_output_regulate_o[gi])
        else $error("shorted channel on outside a burst");
      short_clear_a: assert property (ch_burst[gi] && cmp_f[gi].sls_above && diag_f |=>
        !ch_short[gi])
        else $error("burst saw recovery but short stayed");
      dim_off_a: assert property (!dim_f[gi] |=> !channel_output_regulate_o[gi])
        else $error("current flowing with dim input low");

      // A trip needs the condition clean two edges back
      open_deglitch_a: assert property ($rose(ch_open[gi]) |->
        $past(cmp_f[gi].open_rise_below, 2) && !$past(cmp_f[gi].open_fall_above, 2))
        else $error("open fault raised without deglitch");
      short_deglitch_a: assert property ($rose(ch_short[gi]) |->
        $past(cmp_f[gi].sls_below, 2) && !$past(cmp_f[gi].sls_above, 2))
        else $error("short fault raised without deglitch");

      diag_clear_a: assert property (!diag_f && (ch_open[gi] || ch_short[gi]) |=>
        !ch_open[gi] && !ch_short[gi])
        else $error("held fault survived diagnosis disable");
      open_idle_a: assert property (!diag_f && !ch_open[gi] |=> !ch_open[gi])
        else $error("open fault raised with diagnosis off");
      short_idle_a: assert property (!diag_f && !ch_short[gi] |=> !ch_short[gi])
        else $error("short fault raised with diagnosis off");

      open_recover_a: assert property (ch_open[gi] && cmp_f[gi].open_fall_above |=>
        !ch_open[gi])
        else $error("open fault stayed after headroom returned");
      burst_gate_a: assert property ($rose(ch_burst[gi]) |->
        $past(dim_f[gi]) && !$past(tsd_f))
        else $error("retry burst started while dimmed or hot");

      retry_only_a: assert property (channel_output_retry_o[gi] |->
        channel_open_fault_o[gi])
        else $error("retry current without open fault");
      open_flag_out_a: assert property (ch_open[gi] |=> channel_open_fault_o[gi])
        else $error("open fault not reported");
      short_flag_out_a: assert property (ch_short[gi] |=> channel_short_fault_o[gi])
        else $error("short fault not reported");

      open_cover_c: cover property ($rose(ch_open[gi]));
      burst_cover_c: cover property ($rose(ch_burst[gi]));
      short_clear_c: cover property ($fell(ch_short[gi]));
    end
  endgenerate

  thermal_cover_c: cover property ($rose(tsd_f));
  bus_hold_c: cover property ($rose(bus_hold) && !fault_any);

endmodule

// ### test/lcfs_bus_peer.sv
// Model of another driver device sharing the wired fault bus
`timescale 1ns/1ps
module lcfs_bus_peer (
  input wire logic dut_oe_i,      // Our device sinks the bus
  input wire logic dut_level_i,   // Level our device drives when sinking
  input wire logic peer_fault_i,  // Peer device has a fault of its own
  output logic below_low_o,       // Bus sensed below low threshold
  output logic above_high_o       // Bus sensed above high threshold
);
  // ----------------------------------------------------------------
  // Wired bus
  // ----------------------------------------------------------------
  logic peer_sink;  // Peer strong sink, only while it is faulted
  logic bus_level;  // Resolved level; weak pull-ups lose to any sink
  assign peer_sink = peer_fault_i;
  // Pins tied directly, no buffer transistor, so every sink is seen
  assign bus_level = (dut_oe_i ? dut_level_i : 1'b1) & ~peer_sink;
  // Clean thresholds: the model never leaves the bus between them
  assign below_low_o = ~bus_level;
  assign above_high_o = bus_level;
endmodule

// ### test/lcfs_supervisor_tb.sv
// Self-checking testbench of the LED channel fault supervisor
`timescale 1ns/1ps
module lcfs_supervisor_tb;
  import lcfs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, reset_n, diag, thermal, peer_fault, below_low, above_high;
  logic [2:0] dim, reg_on, retry_on, open_f, short_f;
  logic bus_lvl, bus_oe, bus_pu;
  lcfs_cmp_s [2:0] cmp;  // Healthy is 4'h5: open_fall_above and sls_above
  int error_cnt = 0;
  int compares = 0;
  // Short timings so a retry period fits in a short run
  lcfs_supervisor #(.RETRY_PERIOD_US(20), .RETRY_BURST_US(4), .OPEN_DEG_US(2),
    .SLS_DEG_US(2)) dut (.core_clk_i(clk), .reset_n_i(reset_n), .diag_enable_in_i(diag),
    .channel_dim_in_i(dim), .channel_cmp_i(cmp), .thermal_shutdown_i(thermal),
    .fault_bus_below_low_i(below_low), .fault_bus_above_high_i(above_high),
    .channel_output_regulate_o(reg_on), .channel_output_retry_o(retry_on),
    .channel_open_fault_o(open_f), .channel_short_fault_o(short_f), .fault_bus_o(bus_lvl),
    .fault_bus_oe_o(bus_oe), .fault_bus_weak_pullup_o(bus_pu));
  lcfs_bus_peer peer (.dut_oe_i(bus_oe), .dut_level_i(bus_lvl), .peer_fault_i(peer_fault),
    .below_low_o(below_low), .above_high_o(above_high));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Conditions the waits poll; four-state safe through case equality
  function automatic bit cond(int k);
    case (k)
      0: return reg_on === 3'h7 && bus_oe === 1'b0;
      1: return open_f[0] === 1'b1;
      2: return short_f[1] === 1'b1;
      3: return reg_on[1] === 1'b1;
      4: return reg_on[1] === 1'b0;
      5: return reg_on === 3'h0;
      default: return reg_on === 3'h3;
    endcase
  endfunction
  // Bounded wait; a spent bound is a mismatch and ends the run
  task automatic wait_c(int k, int lim, output int n);
    for (n = 0; n < lim && !cond(k); n++) @(negedge clk);
    if (n == lim) begin
      error_cnt++;
      $display("[FAIL] wait %0d expected met seen timeout", k);
      results();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle();
    int n;
    wait_c(0, 40, n);
    chk("pullup", 8'h01, bus_pu);
    dim = 3'h3;
    wait_c(6, 20, n);
    dim = 3'h7;
    wait_c(0, 20, n);
  endtask
  task automatic t_open();
    int n;
    cmp[0] = 4'h9;
    wait_c(1, 150, n);
    chk("retry", 8'h01, retry_on);
    chk("open_other", 8'h01, open_f);
    chk("bus_oe", 8'h01, bus_oe);
    chk("bus_lvl", 8'h00, bus_lvl);
    chk("pullup_f", 8'h00, bus_pu);
    wait_c(5, 20, n);
    cmp[0] = 4'h5;
    wait_c(0, 40, n);
  endtask
  task automatic t_restart();
    repeat (10) begin
      cmp[0] = 4'h9;
      repeat (20) @(negedge clk);
      cmp[0] = 4'hD;
      repeat (5) @(negedge clk);
    end
    chk("open_rst", 8'h00, open_f);
    cmp[0] = 4'h5;
  endtask
  task automatic t_diag_off();
    diag = 1'b0;
    cmp = {3{4'hA}};
    repeat (300) @(negedge clk);
    chk("open_off", 8'h00, open_f);
    chk("short_off", 8'h00, short_f);
    chk("reg_off", 8'h07, reg_on);
    cmp = {3{4'h5}};
    diag = 1'b1;
  endtask
  task automatic t_short();
    int n;
    cmp[1] = 4'h6;
    wait_c(2, 150, n);
    chk("sls_oe", 8'h01, bus_oe);
    wait_c(3, 700, n);
    wait_c(4, 200, n);
    chk("burst_len", 8'h01, n >= 95 && n <= 105);
    wait_c(3, 700, n);
    chk("gap_len", 8'h01, n >= 395 && n <= 405);
    cmp[1] = 4'h5;
    wait_c(0, 60, n);
  endtask
  task automatic t_thermal();
    int n;
    diag = 1'b0;
    thermal = 1'b1;
    wait_c(5, 20, n);
    chk("tsd_oe", 8'h01, bus_oe);
    thermal = 1'b0;
    wait_c(0, 30, n);
    diag = 1'b1;
  endtask
  task automatic t_peer();
    int n;
    peer_fault = 1'b1;
    wait_c(5, 20, n);
    chk("peer_oe", 8'h00, bus_oe);
    peer_fault = 1'b0;
    wait_c(0, 20, n);
  endtask
  // ----------------------------------------------------------------
  // Main sequence; inputs change on falling edges
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    diag = 1'b1;
    dim = 3'h7;
    thermal = 1'b0;
    peer_fault = 1'b0;
    cmp = {3{4'h5}};
    repeat (5) @(negedge clk);
    chk("rst_pu", 8'h01, bus_pu);
    reset_n = 1'b1;
    t_idle();
    t_open();
    t_restart();
    t_diag_off();
    t_short();
    t_thermal();
    t_peer();
    results();
  end
endmodule
